// ==== hdl/sgq_sequencer.sv ====
// Channel-gain queue sequencer: APB registers, queue stepping, mux and gain lines
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module sgq_sequencer #(
	parameter int RES_BITS   = 12,
	parameter int SETTLE_CYC = sgq_pkg::SETTLE_CYC
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic      [31:0]         prdata,
	output logic                     pslverr,
	input  wire logic                conv_req,
	output logic                     adc_start,
	input  wire logic                adc_done,
	input  wire logic [RES_BITS-1:0] adc_data,
	output logic      [3:0]          chan_sel,
	output logic      [3:0]          exp_chan_sel,
	output logic                     expansion_gain_select_line,
	output logic      [1:0]          pga_gain,
	output logic                     diff_sel,
	output logic                     user_common_mode_reference,
	output logic                     bipolar_sel,
	output logic                     busy
);
	localparam int TW = $clog2(SETTLE_CYC + 1);
	localparam logic [TW-1:0] SETTLE_LAST = TW'(SETTLE_CYC - 1);

	typedef struct packed {
		sgq_pkg::sgq_state_t          st;
		logic                         diff;
		logic                         ucm;
		logic                         bip;
		logic                         run;
		logic [sgq_pkg::QAW-1:0]      qlast;
		logic [sgq_pkg::QAW-1:0]      qaddr;
		logic [sgq_pkg::QAW-1:0]      ptr;
		logic [TW-1:0]                timer;
		logic [sgq_pkg::ENT_W-1:0]    ent;
		logic [RES_BITS-1:0]          result;
		logic [2:0]                   dsync;
		logic                         done_lvl;
		logic                         start;
		logic                         ovr;
		logic [31:0]                  rdata;
		logic                         err;
	} sgq_regs_t;

	sgq_regs_t q_q;
	sgq_regs_t q_d;

	sgq_qmem_if            qm ();
	logic [RES_BITS-1:0]   coded;
	logic                  done_rise;
	logic                  wr_acc;
	logic                  rd_setup;

	////////////////////////////////////////////////////////////////////////////
	// Register index; 3'h7 marks an unmapped address
	function automatic logic [2:0] reg_idx(input logic [7:0] a);
		if (a == sgq_pkg::ADDR_CTRL) begin
			return 3'h0;
		end else if (a == sgq_pkg::ADDR_QLAST) begin
			return 3'h1;
		end else if (a == sgq_pkg::ADDR_QADDR) begin
			return 3'h2;
		end else if (a == sgq_pkg::ADDR_QDATA) begin
			return 3'h3;
		end else if (a == sgq_pkg::ADDR_STATUS) begin
			return 3'h4;
		end else if (a == sgq_pkg::ADDR_RESULT) begin
			return 3'h5;
		end else begin
			return 3'h7;
		end
	endfunction

	sgq_qmem #(
		.DEPTH (sgq_pkg::QDEPTH)
	) u_qmem (
		.pclk (pclk),
		.qm   (qm.mem)
	);

	sgq_coder #(
		.RES_BITS (RES_BITS)
	) u_coder (
		.raw     (adc_data),
		.bipolar (q_q.bip),
		.coded   (coded)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB: read data is latched in the setup cycle, so the access never waits
	assign pready   = psel & penable;
	assign prdata   = q_q.rdata;
	assign pslverr  = psel & penable & q_q.err;
	assign wr_acc   = psel & penable & pwrite & ~q_q.err;
	assign rd_setup = psel & ~penable;

	// A change counts once the last two stages agree: costs a cycle, drops one-cycle glitches
	assign done_rise = q_q.dsync[2] & q_q.dsync[1] & ~q_q.done_lvl;

	// Software loads entries in any order it likes through the address pointer
	assign qm.we       = wr_acc && reg_idx(paddr) == 3'h3;
	assign qm.waddr    = q_q.qaddr;
	assign qm.wdata    = pwdata[sgq_pkg::ENT_W-1:0];
	assign qm.sw_addr  = q_q.qaddr;
	assign qm.seq_addr = q_q.ptr;

	always_comb begin
		q_d       = q_q;
		q_d.start = 1'b0;
		q_d.dsync = {q_q.dsync[1:0], adc_done};
		if (q_q.dsync[1] == q_q.dsync[2]) begin
			q_d.done_lvl = q_q.dsync[2];
		end

		// Read data and error flag for the access phase that follows
		if (rd_setup) begin
			q_d.err   = reg_idx(paddr) == 3'h7;
			q_d.rdata = 32'h0000_0000;
			case (reg_idx(paddr))
				3'h0: begin
					q_d.rdata[sgq_pkg::CTRL_DIFF_BIT] = q_q.diff;
					q_d.rdata[sgq_pkg::CTRL_UCM_BIT]  = q_q.ucm;
					q_d.rdata[sgq_pkg::CTRL_BIP_BIT]  = q_q.bip;
					q_d.rdata[sgq_pkg::CTRL_RUN_BIT]  = q_q.run;
				end
				3'h1: q_d.rdata[sgq_pkg::QAW-1:0] = q_q.qlast;
				3'h2: q_d.rdata[sgq_pkg::QAW-1:0] = q_q.qaddr;
				3'h3: q_d.rdata[sgq_pkg::ENT_W-1:0] = qm.sw_data;
				3'h4: begin
					q_d.rdata[sgq_pkg::STS_PTR_LSB +: sgq_pkg::QAW]   = q_q.ptr;
					q_d.rdata[sgq_pkg::STS_ENT_LSB +: sgq_pkg::ENT_W] = q_q.ent;
					q_d.rdata[sgq_pkg::STS_BUSY_BIT] = q_q.st != sgq_pkg::SGQ_ST_IDLE;
					q_d.rdata[sgq_pkg::STS_OVR_BIT]  = q_q.ovr;
				end
				3'h5: q_d.rdata[RES_BITS-1:0] = q_q.result;
				default: q_d.rdata = 32'h0000_0000;
			endcase
		end

		// Register writes
		if (wr_acc) begin
			case (reg_idx(paddr))
				3'h0: begin
					q_d.diff = pwdata[sgq_pkg::CTRL_DIFF_BIT];
					q_d.ucm  = pwdata[sgq_pkg::CTRL_UCM_BIT];
					q_d.bip  = pwdata[sgq_pkg::CTRL_BIP_BIT];
					q_d.run  = pwdata[sgq_pkg::CTRL_RUN_BIT];
				end
				3'h1: q_d.qlast = pwdata[sgq_pkg::QAW-1:0];
				3'h2: q_d.qaddr = pwdata[sgq_pkg::QAW-1:0];
				3'h3: q_d.qaddr = sgq_pkg::QAW'(q_q.qaddr + 1'b1);
				3'h4: begin
					if (pwdata[sgq_pkg::STS_OVR_BIT]) begin
						q_d.ovr = 1'b0;
					end
				end
				default: q_d.ovr = q_q.ovr;
			endcase
		end

		// Sequencer
		case (q_q.st)
			sgq_pkg::SGQ_ST_IDLE: begin
				if (q_q.run && conv_req) begin
					q_d.ent   = qm.seq_data;
					q_d.timer = SETTLE_LAST;
					q_d.st    = sgq_pkg::SGQ_ST_SETTLE;
				end
			end
			sgq_pkg::SGQ_ST_SETTLE: begin
				if (q_q.timer == '0) begin
					q_d.start = 1'b1;
					q_d.st    = sgq_pkg::SGQ_ST_WAIT;
					if (q_q.ptr == q_q.qlast) begin
						q_d.ptr = sgq_pkg::QPTR_RST;
					end else begin
						q_d.ptr = sgq_pkg::QAW'(q_q.ptr + 1'b1);
					end
				end else begin
					q_d.timer = TW'(q_q.timer - 1'b1);
				end
			end
			sgq_pkg::SGQ_ST_WAIT: begin
				if (done_rise) begin
					q_d.result = coded;
					q_d.st     = sgq_pkg::SGQ_ST_IDLE;
				end
			end
			default: q_d.st = sgq_pkg::SGQ_ST_IDLE;
		endcase

		// A request while a step is in flight is dropped and flagged; set wins
		if (conv_req && q_q.run && q_q.st != sgq_pkg::SGQ_ST_IDLE) begin
			q_d.ovr = 1'b1;
		end

		// Stopping rewinds so the next run begins at the first entry
		if (!q_d.run) begin
			q_d.ptr = sgq_pkg::QPTR_RST;
			if (q_q.st == sgq_pkg::SGQ_ST_SETTLE) begin
				q_d.st    = sgq_pkg::SGQ_ST_IDLE;
				q_d.start = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_q        <= '0;
			q_q.st     <= sgq_pkg::SGQ_ST_IDLE;
			q_q.diff   <= sgq_pkg::CTRL_RST[sgq_pkg::CTRL_DIFF_BIT];
			q_q.ucm    <= sgq_pkg::CTRL_RST[sgq_pkg::CTRL_UCM_BIT];
			q_q.bip    <= sgq_pkg::CTRL_RST[sgq_pkg::CTRL_BIP_BIT];
			q_q.run    <= sgq_pkg::CTRL_RST[sgq_pkg::CTRL_RUN_BIT];
			q_q.qlast  <= sgq_pkg::QLAST_RST;
			q_q.ptr    <= sgq_pkg::QPTR_RST;
		end else begin
			q_q <= q_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drive; all from flops: the held entry, control bits, start pulse and state
	// Differential mode pairs inputs, so only eight channel codes exist
	assign chan_sel = {q_q.ent[3] & ~q_q.diff, q_q.ent[2:0]};
	// Expansion units only work behind single-ended inputs
	assign exp_chan_sel = q_q.diff ? 4'h0 : q_q.ent[sgq_pkg::ENT_EXP_LSB +: 4];
	assign expansion_gain_select_line = q_q.ent[sgq_pkg::ENT_XG_BIT];
	assign pga_gain   = q_q.ent[sgq_pkg::ENT_GAIN_LSB +: 2];
	assign diff_sel   = q_q.diff;
	// In single-ended mode the low side goes to analog ground unless the user reference is chosen
	assign user_common_mode_reference = q_q.ucm & ~q_q.diff;
	assign bipolar_sel = q_q.bip;
	assign adc_start   = q_q.start;
	assign busy        = q_q.st != sgq_pkg::SGQ_ST_IDLE;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_diff_range: assert property (
		diff_sel |-> chan_sel[3] == 1'b0
	) else $error("channel above seven selected in differential mode");

	a_result_zext: assert property (
		(rd_setup && paddr == sgq_pkg::ADDR_RESULT) |=> prdata[31:RES_BITS] == '0
	) else $error("result readback wider than the converter");

	a_ctrl_diff: assert property (
		(wr_acc && paddr == sgq_pkg::ADDR_CTRL)
		|=> diff_sel == $past(pwdata[sgq_pkg::CTRL_DIFF_BIT])
	) else $error("input configuration did not follow the control write");

	a_lowside_se: assert property (
		(wr_acc && paddr == sgq_pkg::ADDR_CTRL)
		|=> user_common_mode_reference == ($past(pwdata[sgq_pkg::CTRL_UCM_BIT])
			&& !$past(pwdata[sgq_pkg::CTRL_DIFF_BIT]))
	) else $error("low side reference does not follow the control write");

	a_code_msb: assert property (
		(q_q.st == sgq_pkg::SGQ_ST_WAIT && done_rise)
		|=> q_q.result[RES_BITS-1] == ($past(adc_data[RES_BITS-1]) ^ bipolar_sel)
	) else $error("result coding does not match the polarity mode");

	a_qaddr_step: assert property (
		qm.we |=> q_q.qaddr == sgq_pkg::QAW'($past(q_q.qaddr) + 1'b1)
	) else $error("queue load pointer did not advance");

	a_exp_single: assert property (
		diff_sel |-> exp_chan_sel == 4'h0
	) else $error("expansion lines driven in differential mode");

	a_exp_follow: assert property (
		(adc_start && !diff_sel) |-> exp_chan_sel == q_q.ent[7:4] ##1 $stable(exp_chan_sel)
	) else $error("expansion select does not carry the entry channel bits");

	a_xgain_follow: assert property (
		adc_start |-> expansion_gain_select_line == q_q.ent[sgq_pkg::ENT_XG_BIT]
	) else $error("expansion gain line does not follow the entry");

	a_gain_follow: assert property (
		(q_q.st == sgq_pkg::SGQ_ST_IDLE && q_q.run && conv_req)
		|=> pga_gain == $past(qm.seq_data[sgq_pkg::ENT_GAIN_LSB +: 2])
	) else $error("on-board gain code does not follow the entry");

	a_settle_first: assert property (
		(q_q.st == sgq_pkg::SGQ_ST_IDLE && q_q.run && conv_req) |=> !adc_start[*2]
	) else $error("sampling started before the entry had settled");

	a_ptr_wrap: assert property (
		(q_q.st == sgq_pkg::SGQ_ST_SETTLE && q_q.timer == '0 && q_q.run)
		|=> q_q.ptr == (($past(q_q.ptr) == q_q.qlast) ? sgq_pkg::QPTR_RST
			: sgq_pkg::QAW'($past(q_q.ptr) + 1'b1))
	) else $error("queue pointer did not advance or wrap");

	a_start_pulse: assert property (
		adc_start |=> !adc_start
	) else $error("converter start longer than one cycle");

	a_chan_load: assert property (
		(q_q.st == sgq_pkg::SGQ_ST_IDLE && q_q.run && conv_req)
		|=> chan_sel[2:0] == $past(qm.seq_data[2:0])
			&& (diff_sel || chan_sel[3] == $past(qm.seq_data[3]))
	) else $error("on-board channel select does not follow the entry");

	a_exp_load: assert property (
		(q_q.st == sgq_pkg::SGQ_ST_IDLE && q_q.run && conv_req && !diff_sel)
		|=> exp_chan_sel == $past(qm.seq_data[sgq_pkg::ENT_EXP_LSB +: 4])
	) else $error("expansion select does not follow the entry");

	a_xgain_load: assert property (
		(q_q.st == sgq_pkg::SGQ_ST_IDLE && q_q.run && conv_req)
		|=> expansion_gain_select_line == $past(qm.seq_data[sgq_pkg::ENT_XG_BIT])
	) else $error("expansion gain line does not follow the entry");

	a_ovr_flag: assert property (
		(conv_req && q_q.run && busy) |=> q_q.ovr
	) else $error("request during a step was not flagged");

	a_stop_rewind: assert property (
		(wr_acc && paddr == sgq_pkg::ADDR_CTRL && !pwdata[sgq_pkg::CTRL_RUN_BIT])
		|=> q_q.ptr == sgq_pkg::QPTR_RST
	) else $error("stopping did not rewind the queue pointer");
endmodule

// ==== hdl/sgq_pkg.sv ====
// Shared constants and types of the channel-gain queue sequencer
package sgq_pkg;

	// Register byte offsets on the APB slave
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_QLAST  = 8'h04;
	localparam logic [7:0] ADDR_QADDR  = 8'h08;
	localparam logic [7:0] ADDR_QDATA  = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_RESULT = 8'h14;

	// Control register fields
	localparam int CTRL_DIFF_BIT = 0;
	localparam int CTRL_UCM_BIT  = 1;
	localparam int CTRL_BIP_BIT  = 2;
	localparam int CTRL_RUN_BIT  = 3;

	// Status register fields
	localparam int STS_PTR_LSB  = 0;
	localparam int STS_ENT_LSB  = 8;
	localparam int STS_BUSY_BIT = 20;
	localparam int STS_OVR_BIT  = 21;

	// Queue entry layout: gain code, expansion gain, expansion channel, channel number
	localparam int QDEPTH       = 256;
	localparam int QAW          = 8;
	localparam int ENT_W        = 11;
	localparam int ENT_CHAN_LSB = 0;
	localparam int ENT_EXP_LSB  = 4;
	localparam int ENT_XG_BIT   = 8;
	localparam int ENT_GAIN_LSB = 9;

	// Reset values
	localparam logic [3:0]     CTRL_RST  = 4'h0;
	localparam logic [QAW-1:0] QLAST_RST = 8'h00;
	localparam logic [QAW-1:0] QPTR_RST  = 8'h00;

	// Input settling time after a new entry is applied
	localparam int CLK_NS     = 50;
	localparam int SETTLE_NS  = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		SGQ_ST_IDLE   = 2'b00,
		SGQ_ST_SETTLE = 2'b01,
		SGQ_ST_WAIT   = 2'b10
	} sgq_state_t;

	// Low-gain variant reads the same codes as 1, 2, 4, 8
	typedef enum logic [1:0] {
		SGQ_GAIN_1   = 2'b00,
		SGQ_GAIN_5   = 2'b01,
		SGQ_GAIN_50  = 2'b10,
		SGQ_GAIN_250 = 2'b11
	} sgq_gain_t;

endpackage

// ==== hdl/sgq_qmem_if.sv ====
// Interface between the sequencer and its queue memory
`timescale 1ns/1ps
interface sgq_qmem_if;
	logic                         we;
	logic [sgq_pkg::QAW-1:0]      waddr;
	logic [sgq_pkg::ENT_W-1:0]    wdata;
	logic [sgq_pkg::QAW-1:0]      sw_addr;
	logic [sgq_pkg::ENT_W-1:0]    sw_data;
	logic [sgq_pkg::QAW-1:0]      seq_addr;
	logic [sgq_pkg::ENT_W-1:0]    seq_data;
	modport user (output we, waddr, wdata, sw_addr, seq_addr, input sw_data, seq_data);
	modport mem  (input we, waddr, wdata, sw_addr, seq_addr, output sw_data, seq_data);
endinterface

// ==== hdl/sgq_qmem.sv ====
// Channel-gain queue memory: one write port, two read ports
`timescale 1ns/1ps
module sgq_qmem #(
	parameter int DEPTH = sgq_pkg::QDEPTH
) (
	input wire logic pclk,
	sgq_qmem_if.mem  qm
);
	logic [sgq_pkg::ENT_W-1:0] mem [DEPTH];

	// No reset: contents are undefined until software loads them
	always_ff @(posedge pclk) begin
		if (qm.we) begin
			mem[qm.waddr] <= qm.wdata;
		end
	end

	assign qm.sw_data  = mem[qm.sw_addr];
	assign qm.seq_data = mem[qm.seq_addr];
endmodule

// ==== hdl/sgq_coder.sv ====
// Result coding: straight binary or two's complement
`timescale 1ns/1ps
module sgq_coder #(
	parameter int RES_BITS = 12
) (
	input  wire logic [RES_BITS-1:0] raw,
	input  wire logic                bipolar,
	output logic      [RES_BITS-1:0] coded
);
	// Converter gives offset binary; flipping the top bit gives two's complement
	always_comb begin
		coded = raw;
		coded[RES_BITS-1] = raw[RES_BITS-1] ^ bipolar;
	end
endmodule

// ==== sim/sgq_adc_model.sv ====
// Converter model: answers each start pulse after a chosen latency
`timescale 1ns/1ps
module sgq_adc_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        adc_start,
	input  wire logic [7:0]  lat,
	input  wire logic [11:0] raw,
	output logic             adc_done,
	output logic      [11:0] adc_data
);
	logic [8:0]  cnt;
	logic [11:0] val;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 9'h000;
			adc_done <= 1'h0;
			adc_data <= 12'h000;
		end else begin
			if (adc_start) begin
				val <= raw;
				cnt <= {1'h0, lat} + 9'h008;
			end else if (cnt != 9'h000) begin
				cnt <= cnt - 9'h001;
			end
			adc_done <= (cnt != 9'h000) && (cnt <= 9'h006);
			// Data settles one cycle ahead of done and stays while done is high;
			// outside that window the data lines keep changing
			if ((cnt != 9'h000) && (cnt <= 9'h007))
				adc_data <= val;
			else
				adc_data <= ~adc_data;
		end
	end
endmodule

// ==== sim/channel_gain_queue_sequencer_test.sv ====
// Self-checking bench of the channel-gain queue sequencer
`timescale 1ns/1ps
module channel_gain_queue_sequencer_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, lat;
	logic [31:0] pwdata, prdata;
	logic        conv_req, adc_start, adc_done, xgain, diff_sel, ucm, bip_sel, busy;
	logic [11:0] adc_data, raw;
	logic [3:0]  chan_sel, exp_sel;
	logic [1:0]  pga_gain;
	logic [13:0] pins;
	logic [32:0] exp_rd[$];
	logic [13:0] exp_pin[$];
	logic [10:0] qent[6];
	int          n_errors, checked;

	sgq_sequencer #(.RES_BITS(12), .SETTLE_CYC(2)) i_sgq_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .conv_req(conv_req),
		.adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
		.chan_sel(chan_sel), .exp_chan_sel(exp_sel),
		.expansion_gain_select_line(xgain), .pga_gain(pga_gain),
		.diff_sel(diff_sel), .user_common_mode_reference(ucm),
		.bipolar_sel(bip_sel), .busy(busy));
	sgq_adc_model i_sgq_adc_model (.pclk(pclk), .presetn(presetn),
		.adc_start(adc_start), .lat(lat), .raw(raw), .adc_done(adc_done),
		.adc_data(adc_data));

	initial begin
		pclk = 1'h0;
		forever #25 pclk = ~pclk;
	end
	assign pins = {bip_sel, ucm, diff_sel, pga_gain, xgain, exp_sel, chan_sel};
////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("errors %0d of %0d checks", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic timeout();
		n_errors++;
		final_report();
	endtask
	task automatic cmp_word(input logic [32:0] got, input logic [32:0] want);
		checked++;
		if (got !== want) begin
			n_errors++;
			$display("unexpected read at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic cmp_pins(input logic [13:0] got, input logic [13:0] want);
		checked++;
		if (got !== want) begin
			n_errors++;
			$display("unexpected pins at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		if (i == 20)
			timeout();
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] want);
		exp_rd.push_back(want);
		apb(1'h0, a, 32'h0);
	endtask
	task automatic step(input logic [10:0] e, input logic [2:0] m, input logic dup);
		int i;
		logic [11:0] r;
		r = 12'($urandom);
		exp_pin.push_back({m[2], m[1] & ~m[0], m[0], e[10:8], m[0] ? 4'h0 : e[7:4],
			m[0] ? {1'h0, e[2:0]} : e[3:0]});
		@(posedge pclk);
		raw <= r;
		lat <= 8'($urandom_range(0, 12));
		conv_req <= 1'h1;
		@(posedge pclk);
		conv_req <= 1'h0;
		for (i = 0; i < 100; i++) begin
			@(posedge pclk);
			// An optional second request lands while the step is settling
			conv_req <= dup && i == 0;
			if (busy === 1'h0)
				break;
		end
		if (i == 100)
			timeout();
		rd(sgq_pkg::ADDR_RESULT, {1'h0, 20'h0, m[2] ? {~r[11], r[10:0]} : r});
	endtask
////////////////////////////////////////////////////////////////////////////////
	// Results are judged where they appear, against notes left by the drivers
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'h1)
			cmp_word({pslverr, prdata}, exp_rd.size() > 0 ? exp_rd.pop_front() : 33'h0);
		if (adc_start === 1'h1)
			cmp_pins(pins, exp_pin.size() > 0 ? exp_pin.pop_front() : ~pins);
	end
	initial begin
		int k, idx;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		conv_req = 1'h0;
		raw = 12'h000;
		lat = 8'h00;
		n_errors = 0;
		checked = 0;
		void'($urandom(32'h664c4112));
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		rd(sgq_pkg::ADDR_CTRL, 33'h0);
		rd(sgq_pkg::ADDR_QLAST, 33'h0);
		rd(sgq_pkg::ADDR_STATUS, 33'h0);
		rd(8'h18, {1'h1, 32'h0});
		apb(1'h1, sgq_pkg::ADDR_QADDR, 32'h000000FF);
		apb(1'h1, sgq_pkg::ADDR_QDATA, 32'h000005A5);
		apb(1'h1, sgq_pkg::ADDR_QADDR, 32'h000000FF);
		rd(sgq_pkg::ADDR_QDATA, {22'h0, 11'h5A5});
		apb(1'h1, sgq_pkg::ADDR_QADDR, 32'h0);
		// Every gain code, then a repeated channel at another gain
		for (k = 0; k < 6; k++) begin
			qent[k] = {2'(k), 9'($urandom)};
			if (k == 5)
				qent[5] = {~qent[1][10:9], qent[1][8:0]};
			apb(1'h1, sgq_pkg::ADDR_QDATA, {21'h0, qent[k]});
		end
		apb(1'h1, sgq_pkg::ADDR_QLAST, 32'h00000005);
		for (k = 0; k < 8; k++) begin
			apb(1'h1, sgq_pkg::ADDR_CTRL, {28'h0, 1'h1, 3'(k)});
			rd(sgq_pkg::ADDR_CTRL, {29'h0, 1'h1, 3'(k)});
			idx = 0;
			for (int s = 0; s < 7; s++) begin
				step(qent[idx], 3'(k), 1'h0);
				idx = (idx == 5) ? 0 : idx + 1;
			end
			apb(1'h1, sgq_pkg::ADDR_CTRL, 32'h0);
		end
		// A second request in flight is dropped and flagged until cleared
		apb(1'h1, sgq_pkg::ADDR_CTRL, 32'h00000008);
		step(qent[0], 3'h0, 1'h1);
		rd(sgq_pkg::ADDR_STATUS, {12'h001, 2'h0, qent[0], 8'h01});
		apb(1'h1, sgq_pkg::ADDR_STATUS, 32'h00200000);
		rd(sgq_pkg::ADDR_STATUS, {14'h0, qent[0], 8'h01});
		apb(1'h1, sgq_pkg::ADDR_CTRL, 32'h0);
		// A request with the sequencer stopped must not start a conversion
		@(posedge pclk);
		conv_req <= 1'h1;
		@(posedge pclk);
		conv_req <= 1'h0;
		repeat (40) @(posedge pclk);
		final_report();
	end
endmodule
